// ==== hdl/err_report_pkg.sv ====
package err_report_pkg;
   localparam int unsigned NUM_CLASS = 18;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // Register byte addresses
   localparam logic [7:0] ENABLE_OFS = 8'h00;
   localparam logic [7:0] MASK_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [17:0] ENABLE_RESET = 18'h00000;
   localparam logic [17:0] MASK_RESET = 18'h00000;
   localparam logic [17:0] STATUS_RESET = 18'h00000;
   // Field positions of the enable register
   localparam int unsigned BIT_LINK_DATA = 17;
   localparam int unsigned BIT_PROTOCOL = 16;
   localparam int unsigned BIT_CACHE_UNCORR = 15;
   localparam int unsigned BIT_CACHE_CORR = 14;
   localparam int unsigned BIT_ACCESS_TABLE = 13;
   localparam int unsigned BIT_TIMEOUT = 12;
   localparam int unsigned BIT_ATOMIC = 11;
   localparam int unsigned BIT_REMAP_WALK = 10;
   localparam int unsigned BIT_TARGET_ABORT = 9;
   localparam int unsigned BIT_MASTER_ABORT = 8;
   localparam int unsigned BIT_SYNC_LO = 5;
   localparam int unsigned BIT_CRC_LO = 2;
   localparam int unsigned BIT_DRAM_UNCORR = 1;
   localparam int unsigned BIT_DRAM_CORR = 0;
   localparam int unsigned NUM_LINK = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] ABORT_FILL = 32'hffffffff;
   localparam int unsigned WDOG_DEFAULT = 1024;
   // One bit per error class, laid out as in the enable register
   typedef struct packed {
      logic link_data;
      logic protocol;
      logic cache_uncorr;
      logic cache_corr;
      logic access_table;
      logic response_timeout;
      logic atomic_cmd;
      logic remap_walk;
      logic target_abort;
      logic master_abort;
      logic [2:0] sync_pkt;
      logic [2:0] crc;
      logic dram_uncorr;
      logic dram_corr;
   } err_class_type;
endpackage

// ==== hdl/report_gate.sv ====
`timescale 1ns/1ns
`default_nettype none
module report_gate (
   input wire logic clock,
   input wire logic srst,
   input wire logic detect,
   input wire logic enable,
   input wire logic masked,
   output logic report_r
);
   always_ff @(posedge clock) begin
      if (srst) begin
         report_r <= 1'b0;
      end else begin
         report_r <= detect & enable & ~masked;
      end
   end

   chk_gate_needs_enable: assert property (
      @(posedge clock) disable iff (srst)
      report_r |-> $past(enable) && $past(detect))
      else $error("report without detect and enable");
endmodule
`default_nettype wire

// ==== hdl/response_watchdog.sv ====
`timescale 1ns/1ns
`default_nettype none
module response_watchdog #(
   parameter int unsigned LIMIT = 1024
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic start,
   input wire logic response,
   output logic busy_r,
   output logic timeout_r
);
   localparam int unsigned CNT_W = $clog2(LIMIT + 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LIMIT - 1);
   logic [CNT_W-1:0] count_r;

   generate
      if (LIMIT < 2) begin : g_bad_limit
         $error("watchdog limit must be at least 2");
      end
   endgenerate

   // Outstanding access tracker; a timeout ends the wait
   always_ff @(posedge clock) begin
      if (srst) begin
         busy_r <= 1'b0;
         count_r <= CNT_ZERO;
         timeout_r <= 1'b0;
      end else begin
         timeout_r <= 1'b0;
         if (busy_r) begin
            if (response) begin
               busy_r <= 1'b0;
            end else if (count_r == CNT_LAST) begin
               busy_r <= 1'b0;
               timeout_r <= 1'b1;
            end else begin
               count_r <= count_r + 1'b1;
            end
         end else if (start) begin
            busy_r <= 1'b1;
            count_r <= CNT_ZERO;
         end
      end
   end

   chk_wdog_fires_once: assert property (
      @(posedge clock) disable iff (srst)
      timeout_r |=> !timeout_r)
      else $error("watchdog timeout longer than one cycle");
endmodule
`default_nettype wire

// ==== hdl/err_report_enables.sv ====
`timescale 1ns/1ns
`default_nettype none
module err_report_enables #(
   parameter int unsigned WDOG_CYCLES = err_report_pkg::WDOG_DEFAULT
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [err_report_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [err_report_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [err_report_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [err_report_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire err_report_pkg::err_class_type err_detect,
   input wire logic access_start,
   input wire logic access_resp,
   output err_report_pkg::err_class_type report,
   output logic dram_uncorr_check_en,
   output logic wdog_complete,
   output logic atomic_err_rsp,
   output logic abort_err_rsp,
   output logic [err_report_pkg::DATA_W-1:0] abort_rsp_data,
   output logic [err_report_pkg::NUM_LINK-1:0] sync_flood
);
   import err_report_pkg::*;

   logic [NUM_CLASS-1:0] enable_r;
   logic [NUM_CLASS-1:0] mask_r;
   logic [NUM_CLASS-1:0] status_r;
   logic [NUM_CLASS-1:0] status_nxt;
   logic [NUM_CLASS-1:0] event_v;
   logic [NUM_CLASS-1:0] report_v;
   err_class_type events;
   logic aw_held_r;
   logic w_held_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [DATA_W-1:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [DATA_W-1:0] rdata_r;
   logic wr_fire;
   logic [DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic [ADDR_W-1:0] wr_addr;
   logic wdog_busy;
   logic wdog_timeout;
   logic atomic_rsp_r;
   logic abort_rsp_r;
   logic [DATA_W-1:0] abort_data_r;
   logic flood_r;

   // Byte-lane merge of a write into a register
   function automatic logic [NUM_CLASS-1:0] merge(
      input logic [NUM_CLASS-1:0] old,
      input logic [DATA_W-1:0] data,
      input logic [3:0] strb
   );
      logic [DATA_W-1:0] word;
      word = DATA_W'(old);
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            word[8*b +: 8] = data[8*b +: 8];
         end
      end
      return word[NUM_CLASS-1:0];
   endfunction

   // Write address and data may arrive in either order
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
   assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
   assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
   assign wr_fire = (aw_held_r || s_axi_awvalid)
      && (w_held_r || s_axi_wvalid) && !bvalid_r;

   always_ff @(posedge clock) begin
      if (srst) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end else if (s_axi_awvalid && !aw_held_r) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         w_held_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= 4'h0;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end else if (s_axi_wvalid && !w_held_r) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         if (wr_addr == ENABLE_OFS || wr_addr == MASK_OFS
               || wr_addr == STATUS_OFS) begin
            bresp_r <= RESP_OKAY;
         end else begin
            bresp_r <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Enable register, one bit per error class
   always_ff @(posedge clock) begin
      if (srst) begin
         enable_r <= ENABLE_RESET;
      end else if (wr_fire && wr_addr == ENABLE_OFS) begin
         enable_r <= merge(enable_r, wr_data, wr_strb);
      end
   end

   // Bank logging mask, one bit per error class
   always_ff @(posedge clock) begin
      if (srst) begin
         mask_r <= MASK_RESET;
      end else if (wr_fire && wr_addr == MASK_OFS) begin
         mask_r <= merge(mask_r, wr_data, wr_strb);
      end
   end

   // Sticky detection status, write one to clear, set wins
   always_comb begin
      status_nxt = status_r;
      if (wr_fire && wr_addr == STATUS_OFS) begin
         status_nxt = status_r & ~merge('0, wr_data, wr_strb);
      end
      status_nxt = status_nxt | event_v;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         status_r <= STATUS_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Read channel
   assign s_axi_arready = !rvalid_r;

   always_ff @(posedge clock) begin
      if (srst) begin
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= '0;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r <= RESP_OKAY;
         case (s_axi_araddr)
            ENABLE_OFS: rdata_r <= DATA_W'(enable_r);
            MASK_OFS: rdata_r <= DATA_W'(mask_r);
            STATUS_OFS: rdata_r <= DATA_W'(status_r);
            default: begin
               rdata_r <= '0;
               rresp_r <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   // Watchdog on system accesses awaiting a response
   response_watchdog #(
      .LIMIT(WDOG_CYCLES)
   ) u_watchdog (
      .clock(clock),
      .srst(srst),
      .start(access_start),
      .response(access_resp),
      .busy_r(wdog_busy),
      .timeout_r(wdog_timeout)
   );

   // Completion of a stalled access never looks at the enable
   assign wdog_complete = wdog_timeout;

   // Masked DRAM uncorrectable errors are not even detected
   assign dram_uncorr_check_en = ~mask_r[BIT_DRAM_UNCORR];

   always_comb begin
      events = err_detect;
      events.response_timeout = wdog_timeout;
      events.dram_uncorr = err_detect.dram_uncorr
         & dram_uncorr_check_en;
   end

   assign event_v = events;

   // One gate per class: detect, enable and bank mask
   generate
      for (genvar i = 0; i < NUM_CLASS; i++) begin : g_gate
         report_gate u_gate (
            .clock(clock),
            .srst(srst),
            .detect(event_v[i]),
            .enable(enable_r[i]),
            .masked(mask_r[i]),
            .report_r(report_v[i])
         );
      end
   endgenerate

   assign report = report_v;

   // Error responses that ignore the reporting enables
   always_ff @(posedge clock) begin
      if (srst) begin
         atomic_rsp_r <= 1'b0;
      end else begin
         atomic_rsp_r <= err_detect.atomic_cmd;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         abort_rsp_r <= 1'b0;
         abort_data_r <= '0;
      end else begin
         abort_rsp_r <= err_detect.target_abort
            | err_detect.master_abort;
         if (err_detect.target_abort || err_detect.master_abort) begin
            abort_data_r <= ABORT_FILL;
         end else begin
            abort_data_r <= '0;
         end
      end
   end

   assign atomic_err_rsp = atomic_rsp_r;
   assign abort_err_rsp = abort_rsp_r;
   assign abort_rsp_data = abort_data_r;

   // Sync flood holds until reset
   always_ff @(posedge clock) begin
      if (srst) begin
         flood_r <= 1'b0;
      end else if (|err_detect.sync_pkt || |err_detect.crc) begin
         flood_r <= 1'b1;
      end
   end

   assign sync_flood = {NUM_LINK{flood_r}};

   sequence s_write_enable;
      wr_fire && wr_addr == ENABLE_OFS && wr_strb == 4'hf;
   endsequence

   chk_enable_write_store: assert property (@(posedge clock)
      disable iff (srst) s_write_enable |=>
      enable_r == $past(wr_data[NUM_CLASS-1:0]))
      else $error("enable write not stored");

   chk_link_data_rpt: assert property (@(posedge clock)
      disable iff (srst) report.link_data == $past(events.link_data
      && enable_r[BIT_LINK_DATA] && !mask_r[BIT_LINK_DATA]))
      else $error("link data report mismatch");

   chk_protocol_rpt: assert property (@(posedge clock)
      disable iff (srst) (err_detect.protocol
      && !enable_r[BIT_PROTOCOL]) |=> !report.protocol)
      else $error("protocol reported while disabled");

   chk_cache_uncorr_rpt: assert property (@(posedge clock)
      disable iff (srst) (err_detect.cache_uncorr
      && enable_r[BIT_CACHE_UNCORR] && !mask_r[BIT_CACHE_UNCORR])
      |=> report.cache_uncorr)
      else $error("cache uncorrectable not reported");

   chk_cache_corr_rpt: assert property (@(posedge clock)
      disable iff (srst) report.cache_corr |->
      $past(enable_r[BIT_CACHE_CORR]))
      else $error("cache correctable reported while disabled");

   chk_access_tbl_rpt: assert property (@(posedge clock)
      disable iff (srst) (err_detect.access_table
      && enable_r[BIT_ACCESS_TABLE] && !mask_r[BIT_ACCESS_TABLE])
      |=> report.access_table)
      else $error("access table error not reported");

   sequence s_timeout_seen;
      wdog_timeout && enable_r[BIT_TIMEOUT] && !mask_r[BIT_TIMEOUT];
   endsequence

   chk_timeout_rpt: assert property (@(posedge clock)
      disable iff (srst) s_timeout_seen |=> report.response_timeout)
      else $error("watchdog timeout not reported");

   chk_wdog_complete: assert property (@(posedge clock)
      disable iff (srst) $rose(wdog_timeout) |-> wdog_complete
      ##1 !wdog_complete)
      else $error("stalled access not completed");

   chk_atomic_rsp: assert property (@(posedge clock)
      disable iff (srst) err_detect.atomic_cmd |=> atomic_err_rsp)
      else $error("atomic command without error response");

   chk_atomic_rpt: assert property (@(posedge clock)
      disable iff (srst) report.atomic_cmd |-> $past(
      err_detect.atomic_cmd && enable_r[BIT_ATOMIC]))
      else $error("atomic report without cause");

   chk_remap_rpt: assert property (@(posedge clock)
      disable iff (srst) report.remap_walk |->
      $past(err_detect.remap_walk))
      else $error("remap walk report without cause");

   chk_abort_rpt: assert property (@(posedge clock)
      disable iff (srst) (report.target_abort || report.master_abort)
      |-> abort_err_rsp)
      else $error("abort reported without error response");

   chk_abort_ones: assert property (@(posedge clock)
      disable iff (srst) (err_detect.target_abort
      || err_detect.master_abort) |=> abort_err_rsp
      && abort_rsp_data == ABORT_FILL)
      else $error("abort response data not all ones");

   chk_sync_rpt: assert property (@(posedge clock)
      disable iff (srst) report.sync_pkt == $past(err_detect.sync_pkt
      & enable_r[BIT_SYNC_LO +: NUM_LINK]
      & ~mask_r[BIT_SYNC_LO +: NUM_LINK]))
      else $error("sync packet report per link wrong");

   chk_crc_rpt: assert property (@(posedge clock)
      disable iff (srst) report.crc == $past(err_detect.crc
      & enable_r[BIT_CRC_LO +: NUM_LINK]
      & ~mask_r[BIT_CRC_LO +: NUM_LINK]))
      else $error("crc report per link wrong");

   chk_flood_start: assert property (@(posedge clock)
      disable iff (srst) (|err_detect.sync_pkt || |err_detect.crc)
      |=> sync_flood == {NUM_LINK{1'b1}} [*3])
      else $error("sync flood missing");

   chk_dram_uncorr_mask: assert property (@(posedge clock)
      disable iff (srst) mask_r[BIT_DRAM_UNCORR] |->
      !event_v[BIT_DRAM_UNCORR] ##1 !report.dram_uncorr)
      else $error("masked uncorrectable DRAM error detected");

   chk_dram_corr_mask: assert property (@(posedge clock)
      disable iff (srst) (err_detect.dram_corr
      && mask_r[BIT_DRAM_CORR]) |=> !report.dram_corr
      && status_r[BIT_DRAM_CORR])
      else $error("masked correctable DRAM error logged");
endmodule
`default_nettype wire

// ==== bench/nb_error_report_enables_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module nb_error_report_enables_bench;
   import err_report_pkg::*;
   localparam int unsigned WDOG = 8;
   typedef struct packed {
      logic [17:0] enable;
      logic [17:0] detect;
      logic [17:0] exp_rpt;
   } row_type;
   logic clock, srst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata, abort_rsp_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, access_start, access_resp;
   err_class_type err_detect, report;
   logic dram_uncorr_check_en, wdog_complete, atomic_err_rsp, abort_err_rsp;
   logic [2:0] sync_flood;
   int bad_count = 0;
   int tests_run = 0;
   row_type rows [5];

   err_report_enables #(.WDOG_CYCLES(WDOG)) i_dut (
      .clock(clock), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .err_detect(err_detect), .access_start(access_start),
      .access_resp(access_resp), .report(report),
      .dram_uncorr_check_en(dram_uncorr_check_en),
      .wdog_complete(wdog_complete), .atomic_err_rsp(atomic_err_rsp),
      .abort_err_rsp(abort_err_rsp), .abort_rsp_data(abort_rsp_data),
      .sync_flood(sync_flood)
   );

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic summarize();
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check_word(input string name, input logic [31:0] e,
         input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, e, s);
      end
   endtask

   task automatic check_class(input string name, input logic [17:0] e,
         input logic [17:0] s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, e, s);
      end
   endtask

   task automatic check_flag(input string name, input logic e,
         input logic s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %b, seen %b", name, e, s);
      end
   endtask

   task automatic give_up(input string name);
      bad_count++;
      $display("unexpected %s: expected answer, seen timeout", name);
      summarize();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int n;
      logic aw_hit, w_hit, b_hit;
      logic [1:0] resp;
      n = 0;
      b_hit = 1'b0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_hit) begin
         @(negedge clock);
         aw_hit = s_axi_awvalid && s_axi_awready;
         w_hit = s_axi_wvalid && s_axi_wready;
         b_hit = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge clock);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
         n++;
         if (n > 50) give_up("bvalid");
      end
      s_axi_bready <= 1'b0;
      check_word("bresp", {30'h0, er}, {30'h0, resp});
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      int n;
      logic ar_hit, r_hit;
      logic [31:0] data;
      logic [1:0] resp;
      n = 0;
      r_hit = 1'b0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_hit) begin
         @(negedge clock);
         ar_hit = s_axi_arvalid && s_axi_arready;
         r_hit = s_axi_rvalid;
         data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clock);
         if (ar_hit) s_axi_arvalid <= 1'b0;
         n++;
         if (n > 50) give_up("rvalid");
      end
      s_axi_rready <= 1'b0;
      check_word("rresp", {30'h0, er}, {30'h0, resp});
      check_word("rdata", ed, data);
   endtask

   // One detection pulse, outputs looked at in the answering cycle
   task automatic fire(input err_class_type d, input logic [17:0] e);
      logic ab;
      ab = d.target_abort | d.master_abort;
      @(posedge clock);
      err_detect <= d;
      @(posedge clock);
      err_detect <= '0;
      @(negedge clock);
      check_class("report", e, report);
      check_flag("atomic_err_rsp", d.atomic_cmd, atomic_err_rsp);
      check_flag("abort_err_rsp", ab, abort_err_rsp);
      check_word("abort_rsp_data", ab ? 32'hffffffff : 32'h0,
         abort_rsp_data);
   endtask

   task automatic do_reset();
      @(posedge clock);
      srst <= 1'b1;
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      @(negedge clock);
      check_flag("awready", 1'b1, s_axi_awready);
      check_flag("arready", 1'b1, s_axi_arready);
      check_flag("check_en", 1'b1, dram_uncorr_check_en);
      check_word("sync_flood", 32'h0, {29'h0, sync_flood});
      axi_read(ENABLE_OFS, 32'h0, RESP_OKAY);
      axi_read(MASK_OFS, 32'h0, RESP_OKAY);
      axi_read(STATUS_OFS, 32'h0, RESP_OKAY);
   endtask

   // Stalled access; timeout report follows only with bit 12 set
   task automatic stall(input logic en);
      int n;
      @(posedge clock);
      access_start <= 1'b1;
      @(posedge clock);
      access_start <= 1'b0;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (wdog_complete !== 1'b1 && n < 40);
      if (n >= 40) give_up("wdog_complete");
      check_flag("wdog late enough", 1'b1, n >= WDOG);
      @(negedge clock);
      check_flag("timeout report", en, report.response_timeout);
   endtask

   initial begin
      srst = 1'b1;
      s_axi_awaddr = 8'h0;
      s_axi_araddr = 8'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      err_detect = '0;
      access_start = 1'b0;
      access_resp = 1'b0;
      rows = '{'{18'h3ffff, 18'h3efff, 18'h3efff},
         '{18'h00000, 18'h3efff, 18'h00000},
         '{18'h2aaaa, 18'h3efff, 18'h2aaaa},
         '{18'h15555, 18'h3efff, 18'h14555},
         '{18'h3ffff, 18'h15555, 18'h14555}};
      do_reset();
      foreach (rows[i]) begin
         axi_write(ENABLE_OFS, {14'h0, rows[i].enable}, RESP_OKAY);
         axi_read(ENABLE_OFS, {14'h0, rows[i].enable}, RESP_OKAY);
         fire(rows[i].detect, rows[i].exp_rpt);
         check_class("again", rows[i].exp_rpt, report);
      end
      axi_read(STATUS_OFS, 32'h0003efff, RESP_OKAY);
      axi_write(STATUS_OFS, 32'h0003ffff, RESP_OKAY);
      axi_read(STATUS_OFS, 32'h0, RESP_OKAY);
      axi_write(8'h0c, 32'h0000ffff, RESP_SLVERR);
      axi_read(8'h0c, 32'h0, RESP_SLVERR);
      axi_write(ENABLE_OFS, 32'hffffffff, RESP_OKAY);
      axi_read(ENABLE_OFS, 32'h0003ffff, RESP_OKAY);
      // Every enable cleared before a warm reset
      axi_write(ENABLE_OFS, 32'h0, RESP_OKAY);
      // Floods start with every enable cleared by reset
      do_reset();
      fire(18'h00004, 18'h0);
      check_word("flood crc", 32'h7, {29'h0, sync_flood});
      do_reset();
      fire(18'h00080, 18'h0);
      check_word("flood sync", 32'h7, {29'h0, sync_flood});
      fire(18'h00300, 18'h0);
      axi_write(ENABLE_OFS, 32'h0003ffff, RESP_OKAY);
      axi_write(MASK_OFS, 32'h00000003, RESP_OKAY);
      @(negedge clock);
      check_flag("check_en masked", 1'b0, dram_uncorr_check_en);
      fire(18'h00003, 18'h0);
      // Sync, aborts and the masked correctable error still detected
      axi_read(STATUS_OFS, 32'h00000381, RESP_OKAY);
      axi_write(MASK_OFS, 32'h0, RESP_OKAY);
      fire(18'h00003, 18'h00003);
      axi_write(ENABLE_OFS, 32'h00001000, RESP_OKAY);
      stall(1'b1);
      axi_write(ENABLE_OFS, 32'h0, RESP_OKAY);
      stall(1'b0);
      @(posedge clock);
      access_start <= 1'b1;
      @(posedge clock);
      access_start <= 1'b0;
      access_resp <= 1'b1;
      @(posedge clock);
      access_resp <= 1'b0;
      repeat (30) begin
         @(negedge clock);
         check_flag("answered", 1'b0, wdog_complete);
      end
      summarize();
   end
endmodule
`default_nettype wire
